// >>> rtl/eif_fifo.sv
// small valid/ready buffer holding received bytes
`timescale 1ns/1ns
`default_nettype none
module eif_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("eif_fifo: DEPTH must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;

   wire logic empty = wr_ptr_r == rd_ptr_r;
   wire logic full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   wire logic push = in_valid_i && !full && ce_i;
   wire logic pop = out_ready_i && !empty && ce_i;

   assign in_ready_o = !full && ce_i;
   assign out_valid_o = !empty;
   // each entry is a register, so the head word is already a flop
   assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/eif_master.sv
// serial eeprom frame master: request side on mclk, bus engine on link clock
//
// Functional notes
// - 11-bit mode: one address byte, low eight bits
// - 11-bit: address bits 10..8 that the size needs (all three at 16 kbit) replace select bits
// - 11-bit write: instr, address, data, stop
// - start/stop: sda edge while scl high
// - instruction is 1010, select bits, rw
// - read: dummy write, repeated start, read instr
// - single read: no ack, then stop
// - burst: ack each byte, nack last, stop
// - burst set up like single-byte read
// - burst only for firmware load requests
// - writes are always single-byte frames
// - 16-bit mode: high then low address byte
// - 16-bit write: four bytes then stop
// - 16-bit: select bits from straps, upper zero
// - one addressing mode from strap, all frames
// - only 7-bit bus device addressing
`timescale 1ns/1ns
`default_nettype none
module eif_master #(
   parameter int SIZE11_KBIT = 16,
   parameter int SIZE16_KBIT = 512,
   parameter int QTR_CYC = eif_pkg::QTR_CYC_DEF,
   parameter int RX_DEPTH = 2
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic lclk_i,
   input wire logic strap_addr16_i,
   input wire logic [2:0] strap_memory_device_select_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic req_fwload_i,
   input wire logic [15:0] req_addr_i,
   input wire logic [7:0] req_wdata_i,
   input wire logic [7:0] req_count_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [7:0] rd_data_o,
   output logic done_o,
   output logic nack_o,
   output logic busy_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o
);
   // ------------------------------------------------------------
   // elaboration checks and address masks
   // ------------------------------------------------------------
   localparam int HI11 = (SIZE11_KBIT >= eif_pkg::SIZE_16K) ? 3 :
                         (SIZE11_KBIT >= eif_pkg::SIZE_8K) ? 2 :
                         (SIZE11_KBIT >= eif_pkg::SIZE_4K) ? 1 : 0;
   localparam logic [2:0] HI11_MASK = 3'((1 << HI11) - 1);
   localparam logic [10:0] MASK11 = 11'(SIZE11_KBIT * eif_pkg::KBIT_BYTES - 1);
   localparam logic [15:0] MASK16 = 16'(SIZE16_KBIT * eif_pkg::KBIT_BYTES - 1);
   localparam int QW = $clog2(QTR_CYC);

   initial begin
      if (SIZE11_KBIT < eif_pkg::SIZE11_MIN || SIZE11_KBIT > eif_pkg::SIZE11_MAX ||
          (SIZE11_KBIT & (SIZE11_KBIT - 1)) != 0) begin
         $error("eif_master: SIZE11_KBIT must be 1, 2, 4, 8 or 16");
      end
      if (SIZE16_KBIT < eif_pkg::SIZE16_MIN || SIZE16_KBIT > eif_pkg::SIZE16_MAX ||
          (SIZE16_KBIT & (SIZE16_KBIT - 1)) != 0) begin
         $error("eif_master: SIZE16_KBIT must be a power of two, 32 to 512");
      end
      if (QTR_CYC < eif_pkg::QTR_CYC_MIN) begin
         $error("eif_master: QTR_CYC too small for the sda synchroniser");
      end
   end

   // scl input is not used: no slave clock stretching is honoured
   logic unused_scl;
   assign unused_scl = scl_i;

   // ------------------------------------------------------------
   // mclk side: straps, request capture, result crossing
   // ------------------------------------------------------------
   logic [3:0] strap_m_r;
   logic [3:0] strap_s_r;
   logic [1:0] strap_cnt_r;
   logic init_done_r;
   logic mode16_r;
   logic [2:0] sel_r;
   logic busy_r;
   logic req_tgl_r;
   logic cmd_wr_r;
   logic [15:0] cmd_addr_r;
   logic [7:0] cmd_wdata_r;
   logic [7:0] cmd_cnt_r;
   logic [2:0] dn_sync_r;
   logic [2:0] rx_sync_r;
   logic rx_pend_r;
   logic ack_tgl_r;
   logic done_r;
   logic nack_r;

   // lclk-side registers read across the crossing (stable when toggled)
   logic done_tgl_r;
   logic rx_tgl_r;
   logic err_r;
   logic [7:0] rx_data_r;

   wire logic req_take = req_valid_i && req_ready_o;
   wire logic dn_edge = dn_sync_r[2] != dn_sync_r[1];
   wire logic rx_edge = rx_sync_r[2] != rx_sync_r[1];
   wire logic fifo_in_ready;
   wire logic rx_push = rx_pend_r && fifo_in_ready;

   assign req_ready_o = ce_i && init_done_r && !busy_r;
   assign busy_o = busy_r;
   assign done_o = done_r;
   assign nack_o = nack_r;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strap_m_r <= '0;
         strap_s_r <= '0;
         strap_cnt_r <= '0;
         init_done_r <= 1'b0;
         mode16_r <= 1'b0;
         sel_r <= '0;
      end else if (ce_i) begin
         strap_m_r <= {strap_addr16_i, strap_memory_device_select_i};
         strap_s_r <= strap_m_r;
         // straps caught once after reset, then held for every frame
         if (!init_done_r) begin
            strap_cnt_r <= strap_cnt_r + 1'b1;
            if (strap_cnt_r == eif_pkg::STRAP_WAIT) begin
               init_done_r <= 1'b1;
               mode16_r <= strap_s_r[3];
               sel_r <= strap_s_r[2:0];
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_r <= 1'b0;
         req_tgl_r <= 1'b0;
         cmd_wr_r <= 1'b0;
         cmd_addr_r <= '0;
         cmd_wdata_r <= '0;
         cmd_cnt_r <= '0;
         done_r <= 1'b0;
         nack_r <= 1'b0;
      end else if (ce_i) begin
         done_r <= 1'b0;
         if (req_take) begin
            busy_r <= 1'b1;
            req_tgl_r <= ~req_tgl_r;
            cmd_wr_r <= req_write_i;
            cmd_addr_r <= req_addr_i;
            cmd_wdata_r <= req_wdata_i;
            // bursts only for firmware load reads, writes stay single
            cmd_cnt_r <= (req_fwload_i && !req_write_i) ? req_count_i : '0;
         end else if (dn_edge) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            nack_r <= err_r;
         end
      end
   end

   // received byte is handed back only once the buffer took it
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dn_sync_r <= '0;
         rx_sync_r <= '0;
         rx_pend_r <= 1'b0;
         ack_tgl_r <= 1'b0;
      end else if (ce_i) begin
         dn_sync_r <= {dn_sync_r[1:0], done_tgl_r};
         rx_sync_r <= {rx_sync_r[1:0], rx_tgl_r};
         if (rx_edge) begin
            rx_pend_r <= 1'b1;
         end else if (rx_push) begin
            rx_pend_r <= 1'b0;
            ack_tgl_r <= ~ack_tgl_r;
         end
      end
   end

   eif_fifo #(
      .WIDTH(8),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .in_valid_i(rx_pend_r),
      .in_ready_o(fifo_in_ready),
      .in_data_i(rx_data_r),
      .out_valid_o(rd_valid_o),
      .out_ready_i(rd_ready_i),
      .out_data_o(rd_data_o)
   );

   // ------------------------------------------------------------
   // lclk side: synchronisers
   // ------------------------------------------------------------
   logic [1:0] ce_l_r;
   logic [1:0] sda_l_r;
   logic [1:0] rq_l_r;
   logic [1:0] ack_l_r;
   logic rq_seen_r;
   logic ack_seen_r;

   always_ff @(posedge lclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ce_l_r <= '0;
         sda_l_r <= 2'h3;
         rq_l_r <= '0;
         ack_l_r <= '0;
      end else begin
         ce_l_r <= {ce_l_r[0], ce_i};
         sda_l_r <= {sda_l_r[0], sda_i};
         rq_l_r <= {rq_l_r[0], req_tgl_r};
         ack_l_r <= {ack_l_r[0], ack_tgl_r};
      end
   end

   wire logic ce_l = ce_l_r[1];
   wire logic sda_s = sda_l_r[1];

   // ------------------------------------------------------------
   // lclk side: frame bytes
   // ------------------------------------------------------------
   eif_pkg::eif_state_t state_r;
   eif_pkg::eif_seg_t seg_r;
   logic [QW-1:0] div_r;
   logic [1:0] q_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic [7:0] cnt_r;
   logic scl_low_r;
   logic sda_low_r;

   // 11-bit mode lends the address bits of 10..8 that the size needs to the select field
   wire logic [2:0] sel_eff = mode16_r ? sel_r :
      ((cmd_addr_r[10:8] & HI11_MASK) | (sel_r & ~HI11_MASK));
   wire logic rw_bit = (seg_r == eif_pkg::SEG_INSTR_RD) ? eif_pkg::RW_READ
                                                        : eif_pkg::RW_WRITE;
   wire logic [7:0] instr_byte = {eif_pkg::DEV_TYPE, sel_eff, rw_bit};
   wire logic [7:0] adr_hi16 = cmd_addr_r[15:8] & MASK16[15:8];
   wire logic [7:0] adr_lo11 = cmd_addr_r[7:0] & MASK11[7:0];
   wire logic [7:0] adr_lo = mode16_r ? cmd_addr_r[7:0] : adr_lo11;
   wire logic new_req = rq_l_r[1] != rq_seen_r;
   wire logic rx_acked = ack_l_r[1] != ack_seen_r;
   wire logic tick = div_r == QW'(QTR_CYC - 1);
   wire logic bit_end = tick && q_r == eif_pkg::Q_LAST;
   wire logic run = state_r != eif_pkg::ST_IDLE && state_r != eif_pkg::ST_WAIT;
   wire logic [7:0] rx_byte = {sh_r[6:0], sda_s};

   // ------------------------------------------------------------
   // lclk side: line levels per quarter bit
   // ------------------------------------------------------------
   logic scl_low_nxt;
   logic sda_low_nxt;
   always_comb begin
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      case (state_r)
         eif_pkg::ST_START: begin
            // sda falls in the second half, scl held high
            scl_low_nxt = q_r == eif_pkg::Q_FIRST;
            sda_low_nxt = q_r >= eif_pkg::Q_SCL_HIGH;
         end
         eif_pkg::ST_STOP: begin
            scl_low_nxt = q_r == eif_pkg::Q_FIRST;
            sda_low_nxt = q_r < eif_pkg::Q_SCL_HIGH;
         end
         eif_pkg::ST_TX: begin
            scl_low_nxt = q_r < eif_pkg::Q_SCL_HIGH;
            // released in the acknowledge slot
            sda_low_nxt = (bit_r != eif_pkg::ACK_BIT) && !sh_r[7];
         end
         eif_pkg::ST_RX: begin
            scl_low_nxt = q_r < eif_pkg::Q_SCL_HIGH;
            sda_low_nxt = 1'b0;
         end
         eif_pkg::ST_RACK: begin
            scl_low_nxt = q_r < eif_pkg::Q_SCL_HIGH;
            sda_low_nxt = cnt_r != '0;
         end
         eif_pkg::ST_WAIT: begin
            // scl parked low until the buffer has taken the received byte
            scl_low_nxt = 1'b1;
            sda_low_nxt = 1'b0;
         end
         default: begin
            scl_low_nxt = 1'b0;
            sda_low_nxt = 1'b0;
         end
      endcase
   end

   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n_o = !scl_low_r;
   assign sda_oe_n_o = !sda_low_r;

   always_ff @(posedge lclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         div_r <= '0;
         q_r <= '0;
      end else if (ce_l) begin
         scl_low_r <= scl_low_nxt;
         sda_low_r <= sda_low_nxt;
         if (!run) begin
            div_r <= '0;
            q_r <= '0;
         end else if (tick) begin
            div_r <= '0;
            q_r <= q_r + 1'b1;
         end else begin
            div_r <= div_r + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // lclk side: frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge lclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= eif_pkg::ST_IDLE;
         seg_r <= eif_pkg::SEG_INSTR_WR;
         bit_r <= '0;
         sh_r <= '0;
         cnt_r <= '0;
         rq_seen_r <= 1'b0;
         ack_seen_r <= 1'b0;
         done_tgl_r <= 1'b0;
         rx_tgl_r <= 1'b0;
         rx_data_r <= '0;
         err_r <= 1'b0;
      end else if (ce_l) begin
         case (state_r)
            eif_pkg::ST_IDLE: begin
               if (new_req) begin
                  rq_seen_r <= rq_l_r[1];
                  err_r <= 1'b0;
                  cnt_r <= cmd_cnt_r;
                  seg_r <= eif_pkg::SEG_INSTR_WR;
                  state_r <= eif_pkg::ST_START;
               end
            end
            eif_pkg::ST_START: begin
               if (bit_end) begin
                  sh_r <= instr_byte;
                  bit_r <= '0;
                  state_r <= eif_pkg::ST_TX;
               end
            end
            eif_pkg::ST_TX: begin
               if (bit_end && bit_r != eif_pkg::ACK_BIT) begin
                  bit_r <= bit_r + 1'b1;
                  sh_r <= {sh_r[6:0], 1'b0};
               end else if (bit_end && sda_s) begin
                  // no acknowledge: end the frame at once
                  err_r <= 1'b1;
                  state_r <= eif_pkg::ST_STOP;
               end else if (bit_end) begin
                  bit_r <= '0;
                  case (seg_r)
                     eif_pkg::SEG_INSTR_WR: begin
                        seg_r <= mode16_r ? eif_pkg::SEG_ADDR_HI
                                          : eif_pkg::SEG_ADDR_LO;
                        sh_r <= mode16_r ? adr_hi16 : adr_lo;
                     end
                     eif_pkg::SEG_ADDR_HI: begin
                        seg_r <= eif_pkg::SEG_ADDR_LO;
                        sh_r <= adr_lo;
                     end
                     eif_pkg::SEG_ADDR_LO: begin
                        if (cmd_wr_r) begin
                           seg_r <= eif_pkg::SEG_DATA;
                           sh_r <= cmd_wdata_r;
                        end else begin
                           // dummy write ends here, repeated start follows
                           seg_r <= eif_pkg::SEG_INSTR_RD;
                           state_r <= eif_pkg::ST_START;
                        end
                     end
                     eif_pkg::SEG_DATA: begin
                        state_r <= eif_pkg::ST_STOP;
                     end
                     default: begin
                        state_r <= eif_pkg::ST_RX;
                     end
                  endcase
               end
            end
            eif_pkg::ST_RX: begin
               if (bit_end) begin
                  sh_r <= rx_byte;
                  bit_r <= bit_r + 1'b1;
                  if (bit_r == eif_pkg::LAST_DATA_BIT) begin
                     rx_data_r <= rx_byte;
                     rx_tgl_r <= ~rx_tgl_r;
                     state_r <= eif_pkg::ST_WAIT;
                  end
               end
            end
            eif_pkg::ST_WAIT: begin
               if (rx_acked) begin
                  ack_seen_r <= ack_l_r[1];
                  state_r <= eif_pkg::ST_RACK;
               end
            end
            eif_pkg::ST_RACK: begin
               if (bit_end && cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
                  bit_r <= '0;
                  state_r <= eif_pkg::ST_RX;
               end else if (bit_end) begin
                  state_r <= eif_pkg::ST_STOP;
               end
            end
            eif_pkg::ST_STOP: begin
               if (bit_end) begin
                  done_tgl_r <= ~done_tgl_r;
                  state_r <= eif_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= eif_pkg::ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> rtl/eif_pkg.sv
// constants and types shared by the serial eeprom frame master
package eif_pkg;

   // ------------------------------------------------------------
   // bus framing
   // ------------------------------------------------------------
   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [1:0] Q_FIRST = 2'h0;
   localparam logic [1:0] Q_SCL_HIGH = 2'h2;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam int KBIT_BYTES = 128;

   // ------------------------------------------------------------
   // memory sizes in kbit
   // ------------------------------------------------------------
   localparam int SIZE11_MIN = 1;
   localparam int SIZE11_MAX = 16;
   localparam int SIZE16_MIN = 32;
   localparam int SIZE16_MAX = 512;
   localparam int SIZE_4K = 4;
   localparam int SIZE_8K = 8;
   localparam int SIZE_16K = 16;

   // ------------------------------------------------------------
   // timing and start-up
   // ------------------------------------------------------------
   localparam int QTR_CYC_DEF = 4;
   localparam int QTR_CYC_MIN = 3;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // ------------------------------------------------------------
   // engine states and byte slots of a frame
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_TX,
      ST_RX,
      ST_WAIT,
      ST_RACK,
      ST_STOP
   } eif_state_t;

   typedef enum logic [2:0] {
      SEG_INSTR_WR,
      SEG_ADDR_HI,
      SEG_ADDR_LO,
      SEG_DATA,
      SEG_INSTR_RD
   } eif_seg_t;

endpackage

// >>> test/eif_eeprom_model.sv
// behavioural serial eeprom on the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module eif_eeprom_model (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic mode16_i,
   output logic sda_low_o
);
   logic [7:0] mem [logic [15:0]];
   logic [7:0] rx_q [$];
   logic [7:0] sh = 8'h00, ins = 8'h00, dout = 8'hFF;
   logic [15:0] ad = 16'h0000;
   // mute: bench asks for a refused frame
   logic rdm = 1'b0, pend = 1'b0, nak = 1'b0, mute = 1'b0;
   int bc = 0, nb = 0;
   initial sda_low_o = 1'b0;
   // ------------------------------------------------------------
   // wire decoding
   // ------------------------------------------------------------
   function automatic logic [7:0] peek(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5A;
   endfunction
   task automatic take(input logic [7:0] b);
      rx_q.push_back(b);
      if (nb == 0) ins = b;
      if (nb == 0) pend = b[0];
      else if (mode16_i && nb == 1) ad[15:8] = b;
      else if (nb == (mode16_i ? 2 : 1)) ad = mode16_i ? {ad[15:8], b} : {5'h00, ins[3:1], b};
      else mem[ad] = b;
      nb++;
   endtask
   // checked 1 ns late: sda moving with the scl fall is no start
   always @(negedge sda_i) begin
      #1;
      if (scl_i === 1'b1) begin
         bc = 0;
         nb = 0;
         rdm = 1'b0;
         nak = 1'b0;
      end
   end
   always @(posedge scl_i) begin
      if (bc < 8 && !rdm) sh = {sh[6:0], sda_i};
      if (bc == 8 && rdm && sda_i) nak = 1'b1;
      if (bc == 8 && rdm && !sda_i) ad = ad + 16'h0001;
      if (bc == 8 && rdm) dout = peek(ad);
      bc++;
   end
   always @(negedge scl_i) begin
      if (bc == 8) sda_low_o = !rdm && !mute;
      if (bc == 8 && !rdm) take(sh);
      if (bc == 9) bc = 0;
      if (bc == 0 && pend) rdm = 1'b1;
      if (bc == 0 && pend) dout = peek(ad);
      if (bc == 0) pend = 1'b0;
      if (bc < 8) sda_low_o = rdm && !nak && !dout[7 - bc];
   end
endmodule
`default_nettype wire

// >>> test/eif_master_assertions.sv
// port assertions for the eeprom frame master
`timescale 1ns/1ns
`default_nettype none
module eif_master_assertions #(
   parameter int QTR_CYC = 4
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic lclk_i,
   input wire logic req_ready_o,
   input wire logic req_valid_i,
   input wire logic rd_valid_o,
   input wire logic rd_ready_i,
   input wire logic [7:0] rd_data_o,
   input wire logic done_o,
   input wire logic busy_o,
   input wire logic scl_oe_n_o,
   input wire logic sda_oe_n_o
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   // counts are lower bounds, so they hold for any QTR_CYC of 3 or more
   sequence s_start_hold;
      (scl_oe_n_o && !sda_oe_n_o) [*6];
   endsequence
   sequence s_bus_free;
      (scl_oe_n_o && sda_oe_n_o) [*6];
   endsequence
   chk_start_hold: assert property (@(posedge lclk_i) disable iff (!resetn_i)
      $fell(sda_oe_n_o) && scl_oe_n_o |-> s_start_hold) else $error("start too short");
   chk_stop_free: assert property (@(posedge lclk_i) disable iff (!resetn_i)
      $rose(sda_oe_n_o) && scl_oe_n_o |-> s_bus_free) else $error("stop too short");
   chk_scl_high: assert property (@(posedge lclk_i) disable iff (!resetn_i)
      $rose(scl_oe_n_o) |-> scl_oe_n_o [*6]) else $error("scl high too short");
   chk_scl_low: assert property (@(posedge lclk_i) disable iff (!resetn_i)
      $fell(scl_oe_n_o) |-> !scl_oe_n_o [*3]) else $error("scl low too short");
   chk_idle_free: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !busy_o |-> scl_oe_n_o && sda_oe_n_o) else $error("bus held while idle");
   chk_done_ends: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      done_o |-> !busy_o && $past(busy_o)) else $error("done without busy");
   chk_take_busy: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      req_valid_i && req_ready_o |=> busy_o && !req_ready_o) else $error("take without busy");
   chk_rd_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o)) else $error("byte lost");
endmodule
bind eif_master eif_master_assertions #(.QTR_CYC(QTR_CYC)) eif_master_assertions_inst (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .lclk_i(lclk_i), .req_ready_o(req_ready_o),
   .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o),
   .done_o(done_o), .busy_o(busy_o), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o),
   .req_valid_i(req_valid_i)
);
`default_nettype wire

// >>> test/eif_master_bench.sv
// self-checking bench for the eeprom frame master
`timescale 1ns/1ns
`default_nettype none
module eif_master_bench;
   logic mclk_i = 1'b0;
   logic lclk = 1'b0;
   logic resetn_i = 1'b0;
   logic m16 = 1'b0, rq_v = 1'b0, rq_w = 1'b0, rq_fw = 1'b0, rd_rdy = 1'b0;
   logic ce = 1'b1;
   logic [2:0] sel = 3'h5;
   logic [15:0] rq_a = 16'h0000;
   logic [7:0] rq_d = 8'h00, rq_c = 8'h00;
   wire logic rq_rdy, rd_v, done, nack, busy, scl_oen, sda_oen, ee_low, scl_do, sda_do;
   wire logic [7:0] rd_d;
   // both lines have pull-ups
   wire logic scl_w = scl_oen;
   wire logic sda_w = sda_oen & ~ee_low;
   logic [7:0] mem [logic [15:0]];
   int error_cnt = 0, n_compared = 0, n_done = 0;
   always #5 mclk_i = ~mclk_i;
   initial begin
      #3;
      forever #80 lclk = ~lclk;
   end
   always @(posedge mclk_i) if (done === 1'b1) n_done <= n_done + 1;
   eif_master #(.QTR_CYC(3)) eif_master_inst (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce), .lclk_i(lclk),
      .strap_addr16_i(m16), .strap_memory_device_select_i(sel),
      .req_valid_i(rq_v), .req_ready_o(rq_rdy), .req_write_i(rq_w), .req_fwload_i(rq_fw),
      .req_addr_i(rq_a), .req_wdata_i(rq_d), .req_count_i(rq_c),
      .rd_valid_o(rd_v), .rd_ready_i(rd_rdy), .rd_data_o(rd_d), .done_o(done),
      .nack_o(nack), .busy_o(busy), .scl_i(scl_w), .scl_o(scl_do), .scl_oe_n_o(scl_oen),
      .sda_i(sda_w), .sda_o(sda_do), .sda_oe_n_o(sda_oen)
   );
   eif_eeprom_model eif_eeprom_model_inst (
      .scl_i(scl_w), .sda_i(sda_w), .mode16_i(m16), .sda_low_o(ee_low)
   );
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(inout int k, input int lim);
      @(posedge mclk_i);
      k++;
      if (k >= lim) error_cnt++;
      if (k >= lim) wrap_up();
   endtask
   function automatic logic [7:0] mv(input logic [15:0] a);
      return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5A;
   endfunction
   task automatic rst(input logic m);
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      m16 <= m;
      sel <= m ? 3'h6 : 3'h5;
      repeat (8) @(posedge mclk_i);
      resetn_i <= 1'b1;
   endtask
   task automatic op(input logic w, input logic fw, input logic [15:0] a, input logic [7:0] c,
                     input logic nk);
      logic [7:0] e [$];
      logic [7:0] ins;
      logic [7:0] d;
      int k, n;
      d = 8'($urandom());
      ins = {4'hA, m16 ? sel : a[10:8], 1'b0};
      e = {ins};
      if (m16) e.push_back(a[15:8]);
      e.push_back(a[7:0]);
      e.push_back(w ? d : ins | 8'h01);
      // a refused instruction ends the frame after its first byte
      if (nk) e = {ins};
      if (w && !nk) mem[a] = d;
      n = n_done;
      eif_eeprom_model_inst.rx_q.delete();
      eif_eeprom_model_inst.mute = nk;
      rq_v <= 1'b1;
      rq_w <= w;
      rq_fw <= fw;
      rq_a <= a;
      rq_d <= d;
      rq_c <= c;
      k = 0;
      do tick(k, 100); while (rq_rdy !== 1'b1);
      rq_v <= 1'b0;
      k = 0;
      if (!w) while (rd_v !== 1'b1) tick(k, 20000);
      // far side stalls while the buffer fills; clock enable dips meanwhile
      if (!w && fw) ce <= 1'b0;
      if (!w && fw) repeat (40) @(posedge mclk_i);
      ce <= 1'b1;
      if (!w && fw) repeat (4000) @(posedge mclk_i);
      if (!w) rd_rdy <= 1'b1;
      for (int i = 0; !w && i <= (fw ? int'(c) : 0); i++) begin
         k = 0;
         do tick(k, 20000); while (rd_v !== 1'b1);
         chk(rd_d, mv(a + 16'(i)));
      end
      rd_rdy <= 1'b0;
      k = 0;
      while (n_done == n) tick(k, 40000);
      chk(nack, nk);
      chk(busy, 1'b0);
      chk(16'({scl_do, sda_do}), 16'h0000);
      chk(rd_v, 1'b0);
      chk(16'(eif_eeprom_model_inst.rx_q.size()), 16'(e.size()));
      foreach (e[j]) chk(eif_eeprom_model_inst.rx_q[j], e[j]);
   endtask
   initial begin
      logic [15:0] a;
      void'($urandom(32'hCB69A987));
      for (int m = 0; m < 2; m++) begin
         rst(m[0]);
         a = 16'($urandom()) & (m[0] ? 16'hFFF0 : 16'h07F0);
         op(1'b1, 1'b1, a, 8'h03, 1'b0);
         op(1'b1, 1'b0, a, 8'h00, 1'b1);
         op(1'b0, 1'b0, a, 8'h03, 1'b0);
         op(1'b0, 1'b1, a, 8'h02, 1'b0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
